// File: shared/dphdmi_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz sys_clk, Avalon word addressing
// Notes:   included by bare name
`ifndef DPHDMI_DEFINES_SVH
`define DPHDMI_DEFINES_SVH
`define CLK_MHZ        100
`define CLK_PERIOD_NS  10
// register word addresses
`define REG_CTRL       4'h0
`define REG_LANEMAP    4'h1
`define REG_STEREO     4'h2
`define REG_STATUS     4'h3
`define REG_EVENT      4'h4
`define REG_LINKCNT    4'h5
`define REG_PKTCNT     4'h6
// control fields
`define CTRL_EN        0
`define CTRL_HDMI      1
`define CTRL_TMAN      2
`define CTRL_IRQ       3
`define CTRL_YCC       6
`define CTRL_S422      7
`define CTRL_RESET     16'h0000
`define LANEMAP_RESET  16'he4e4
// timing
`define HPD_PULSE_US   750
`define HPD_IRQ_MAX_US 1000
`define HPD_LOSS_US    2000
`define AUX_BIT_NS     1000
`define AUX_BIT_CYC    (`AUX_BIT_NS / `CLK_PERIOD_NS)
`define LINK_WIN_CYC   1024
`define LINK_MIN       16'h0040
`define LINK_MAX       16'h0100
`define TERM_CAL_CYC   64
`define TERM_MID       4'h8
// link bring-up: last step index per mode
`define DP_LAST_STEP   3'h4
`define HDMI_LAST_STEP 3'h7
// island coding
`define BCH_POLY       8'h83
`define BCH_DATA_BITS  5'h18
`define PT_ACR         8'h01
`define PT_GCP         8'h03
`define PT_AVI         8'h82
`endif

// File: shared/dphdmi_pkg.sv
// Purpose: carrier types of the converter
// Assumes: nothing
// Notes:   constants live in dphdmi_defines.svh
package dphdmi_pkg;
    typedef struct packed {
        logic        de;
        logic        hs;
        logic        vs;
        logic [15:0] r;
        logic [15:0] g;
        logic [15:0] b;
    } vid_t;
    typedef struct packed {
        logic       valid;
        logic       hdr;
        logic [3:0] d1;
        logic [3:0] d2;
    } isl_t;
    typedef struct packed {
        logic        valid;
        logic        layout8;
        logic [2:0]  ch;
        logic [31:0] data;
    } aud_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] ptype;
    } pkt_t;
    typedef struct packed {
        logic [9:0] ch2;
        logic [9:0] ch1;
        logic [9:0] ch0;
    } tmds_t;
    typedef enum logic [1:0] {ST_OFF, ST_TRAIN, ST_RUN} rx_state_t;
endpackage

// File: rtl/dp_hdmi_stream_converter.sv
// Purpose: receive bring-up, hot-plug, lane map, termination, stereo map,
//          HDMI TMDS/TERC4 formatter with BCH on island headers
// Assumes: video, island, audio and packet inputs share sys_clk
`timescale 1ns/1ps
`include "dphdmi_defines.svh"
module dp_hdmi_stream_converter #(
    parameter logic [17:0] HPD_PULSE_CYC   = 18'(`HPD_PULSE_US * `CLK_MHZ),
    parameter logic [17:0] HPD_IRQ_MAX_CYC = 18'(`HPD_IRQ_MAX_US * `CLK_MHZ),
    parameter logic [17:0] HPD_LOSS_CYC    = 18'(`HPD_LOSS_US * `CLK_MHZ)
) (
    input  logic              sys_clk,
    input  logic              nrst,
    input  logic [3:0]        avs_address,
    input  logic              avs_read,
    input  logic              avs_write,
    input  logic [31:0]       avs_writedata,
    input  logic [3:0]        avs_byteenable,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest,
    input  logic              link_clk,
    input  logic              hpd_in,
    input  logic [7:0]        rx_step_ok,
    input  logic [3:0]        rx_lane_lock,
    input  logic              term_cal_hi,
    input  dphdmi_pkg::vid_t  vid_in,
    input  dphdmi_pkg::isl_t  isl_in,
    input  dphdmi_pkg::aud_t  aud_in,
    input  dphdmi_pkg::pkt_t  pkt_in,
    output logic              hpd_out,
    output logic              aux_req,
    output logic [1:0]        aux_kind,
    output logic              aux_tick,
    output logic [2:0]        rx_step,
    output logic [7:0]        lane_sel,
    output logic [3:0]        term_code,
    output logic              vid_ready,
    output dphdmi_pkg::tmds_t tmds,
    output dphdmi_pkg::aud_t  aud_out,
    output logic              vsif_3d_valid,
    output logic [3:0]        vsif_3d_struct
);

////////////////////////////////////////////////////////////////////////
// helpers

    // tmds word: returns {new disparity, code}
    function automatic logic [14:0] tmds_enc(input logic [7:0] d,
                                             input logic [4:0] c);
        logic [8:0] m;
        logic [3:0] n1;
        logic [4:0] df;
        logic [4:0] cn;
        logic [9:0] q;
        logic       x;
        n1 = 4'h0;
        for (int i = 0; i < 8; i++) n1 = n1 + {3'h0, d[i]};
        x = (n1 > 4'h4) || (n1 == 4'h4 && !d[0]);
        m[0] = d[0];
        for (int i = 1; i < 8; i++) m[i] = x ^ m[i-1] ^ d[i];
        m[8] = ~x;
        n1 = 4'h0;
        for (int i = 0; i < 8; i++) n1 = n1 + {3'h0, m[i]};
        df = {n1, 1'b0} - 5'h08;
        if (c == 5'h00 || df == 5'h00) begin
            q  = {~m[8], m[8], m[8] ? m[7:0] : ~m[7:0]};
            cn = m[8] ? c + df : c - df;
        end else if (c[4] == df[4]) begin
            q  = {1'b1, m[8], ~m[7:0]};
            cn = c + {3'h0, m[8], 1'b0} - df;
        end else begin
            q  = {1'b0, m[8], m[7:0]};
            cn = c - {3'h0, ~m[8], 1'b0} + df;
        end
        return {cn, q};
    endfunction

    // terc4 nibble to 10-bit symbol
    function automatic logic [9:0] terc4(input logic [3:0] n);
        case (n)
            4'h0: return 10'h29c;
            4'h1: return 10'h263;
            4'h2: return 10'h2e4;
            4'h3: return 10'h2e2;
            4'h4: return 10'h171;
            4'h5: return 10'h11e;
            4'h6: return 10'h18e;
            4'h7: return 10'h13c;
            4'h8: return 10'h2cc;
            4'h9: return 10'h139;
            4'ha: return 10'h19c;
            4'hb: return 10'h2c6;
            4'hc: return 10'h28e;
            4'hd: return 10'h271;
            4'he: return 10'h163;
            default: return 10'h2c3;
        endcase
    endfunction

    // control token from {vs, hs}
    function automatic logic [9:0] ctl_tok(input logic [1:0] s);
        case (s)
            2'h0: return 10'h354;
            2'h1: return 10'h0ab;
            2'h2: return 10'h154;
            default: return 10'h2ab;
        endcase
    endfunction

    // stereo code to {valid, hdmi 3d structure}
    function automatic logic [4:0] map3d(input logic [7:0] c);
        case (c)
            8'h01, 8'h11, 8'h21, 8'h02: return 5'h10;
            8'h03, 8'h13:               return 5'h12;
            8'h04, 8'h14:               return 5'h13;
            default:                    return 5'h00;
        endcase
    endfunction

////////////////////////////////////////////////////////////////////////
// pin synchronisers

    logic [14:0] s1_q;
    logic [14:0] s2_q;
    logic [1:0]  prev_q;

    // two flops for link_clk, hpd_in, term_cal_hi, rx_lane_lock and rx_step_ok
    always_ff @(posedge sys_clk) begin
        s1_q <= {link_clk, hpd_in, term_cal_hi, rx_lane_lock, rx_step_ok};
        s2_q <= s1_q;
        prev_q <= s2_q[14:13];
    end

    wire [7:0] step_ok_s = s2_q[7:0];
    wire [3:0] lock_s    = s2_q[11:8];
    wire       cal_hi_s  = s2_q[12];
    wire       hpd_s     = s2_q[13];
    wire       lclk_s    = s2_q[14];
    wire       lclk_rise = lclk_s & ~prev_q[1];
    wire       hpd_rise  = hpd_s & ~prev_q[0];

////////////////////////////////////////////////////////////////////////
// avalon slave

    logic        wait_q;
    logic [31:0] rdata_q;
    logic [15:0] ctrl_q;
    logic [15:0] lanemap_q;
    logic [7:0]  stereo_q;
    logic [1:0]  evt_q;

    wire        req  = avs_read | avs_write;
    wire        acc  = req & ~wait_q;
    wire        wr   = avs_write & acc;
    wire [31:0] wm   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wval = avs_writedata & wm;
    wire        wr_ctrl = wr && avs_address == `REG_CTRL;
    wire        wr_lmap = wr && avs_address == `REG_LANEMAP;
    wire        wr_ster = wr && avs_address == `REG_STEREO;
    wire        wr_evt  = wr && avs_address == `REG_EVENT;
    wire [15:0] ctrl_d  = ((ctrl_q & ~wm[15:0]) | wval[15:0]) & 16'hfff7;
    wire [15:0] lmap_d  = (lanemap_q & ~wm[15:0]) | wval[15:0];
    wire [7:0]  ster_d  = (stereo_q & ~wm[7:0]) | wval[7:0];
    wire        irq_wr  = wr_ctrl & wval[`CTRL_IRQ];

    // control fields
    wire       rx_en    = ctrl_q[`CTRL_EN];
    wire       hdmi     = ctrl_q[`CTRL_HDMI];
    wire       t_man    = ctrl_q[`CTRL_TMAN];
    wire [1:0] rep      = ctrl_q[5:4];
    wire [3:0] t_val    = ctrl_q[11:8];
    wire       fmt_err  = ctrl_q[`CTRL_S422] & ~ctrl_q[`CTRL_YCC];

    logic [31:0] rd_mux;
    logic [31:0] status_w;
    logic [15:0] linkcnt_q;
    logic [31:0] pktcnt_q;

    // one wait cycle, then data and write take effect
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wait_q    <= 1'b1;
            rdata_q   <= 32'h0;
            ctrl_q    <= `CTRL_RESET;
            lanemap_q <= `LANEMAP_RESET;
            stereo_q  <= 8'h00;
        end else begin
            wait_q <= ~(req & wait_q);
            if (req & wait_q) rdata_q <= rd_mux;
            if (wr_ctrl) ctrl_q <= ctrl_d;
            if (wr_lmap) lanemap_q <= lmap_d;
            if (wr_ster) stereo_q <= ster_d;
        end
    end

    assign rd_mux = (avs_address == `REG_CTRL)    ? {16'h0, ctrl_q} :
                    (avs_address == `REG_LANEMAP) ? {16'h0, lanemap_q} :
                    (avs_address == `REG_STEREO)  ? {15'h0, vsif_3d_valid,
                                                     4'h0, vsif_3d_struct,
                                                     stereo_q} :
                    (avs_address == `REG_STATUS)  ? status_w :
                    (avs_address == `REG_EVENT)   ? {30'h0, evt_q} :
                    (avs_address == `REG_LINKCNT) ? {16'h0, linkcnt_q} :
                    (avs_address == `REG_PKTCNT)  ? pktcnt_q : 32'h0;

    assign avs_waitrequest = wait_q;
    assign avs_readdata    = rdata_q;

////////////////////////////////////////////////////////////////////////
// receive bring-up

    dphdmi_pkg::rx_state_t st_q;
    logic [2:0] step_q;

    wire [2:0] last    = hdmi ? `HDMI_LAST_STEP : `DP_LAST_STEP;
    wire [7:0] need    = 8'((9'h2 << last) - 9'h1);
    wire       all_ok  = (step_ok_s & need) == need;
    wire       ready   = st_q == dphdmi_pkg::ST_RUN;

    // each step waits for the previous one, in mode order
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_q   <= dphdmi_pkg::ST_OFF;
            step_q <= 3'h0;
        end else begin
            case (st_q)
                dphdmi_pkg::ST_OFF: begin
                    step_q <= 3'h0;
                    if (rx_en) st_q <= dphdmi_pkg::ST_TRAIN;
                end
                dphdmi_pkg::ST_TRAIN: begin
                    if (!rx_en) begin
                        st_q <= dphdmi_pkg::ST_OFF;
                    end else if (step_ok_s[step_q]) begin
                        if (step_q == last) st_q <= dphdmi_pkg::ST_RUN;
                        else step_q <= step_q + 3'h1;
                    end
                end
                dphdmi_pkg::ST_RUN: begin
                    if (!rx_en) begin
                        st_q <= dphdmi_pkg::ST_OFF;
                    end else if (!all_ok) begin
                        st_q   <= dphdmi_pkg::ST_TRAIN;
                        step_q <= 3'h0;
                    end
                end
                default: st_q <= dphdmi_pkg::ST_OFF;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////
// hot-plug out, hot-plug in, aux

    logic [17:0] pulse_q;
    logic [17:0] low_q;
    logic        present_q;
    logic [6:0]  auxdiv_q;

    wire sink_irq  = hpd_rise && present_q && low_q < HPD_IRQ_MAX_CYC;
    wire sink_loss = present_q && !hpd_s && low_q >= HPD_LOSS_CYC;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pulse_q   <= 18'h0;
            hpd_out   <= 1'b0;
            low_q     <= 18'h0;
            present_q <= 1'b0;
            evt_q     <= 2'h0;
            aux_req   <= 1'b0;
            aux_kind  <= 2'h0;
            auxdiv_q  <= 7'h0;
            aux_tick  <= 1'b0;
        end else begin
            if (irq_wr && ready && pulse_q == 18'h0) pulse_q <= HPD_PULSE_CYC;
            else if (pulse_q != 18'h0) pulse_q <= pulse_q - 18'h1;
            hpd_out <= ready && pulse_q == 18'h0;
            if (hpd_s) low_q <= 18'h0;
            else if (low_q != 18'h3ffff) low_q <= low_q + 18'h1;
            if (hpd_s) present_q <= 1'b1;
            else if (sink_loss) present_q <= 1'b0;
            // set wins over a clear in the same cycle
            evt_q <= (evt_q & ~({2{wr_evt}} & wval[1:0])) |
                     {sink_loss, sink_irq};
            aux_req  <= sink_irq;
            aux_kind <= ctrl_q[13:12];
            if (auxdiv_q == 7'(`AUX_BIT_CYC - 1)) auxdiv_q <= 7'h0;
            else auxdiv_q <= auxdiv_q + 7'h1;
            aux_tick <= auxdiv_q == 7'h0;
        end
    end

////////////////////////////////////////////////////////////////////////
// link clock measure, lane map, termination

    logic [9:0]  win_q;
    logic [15:0] edges_q;
    logic        link_ok_q;
    logic [5:0]  cal_q;

    wire [7:0] map = hdmi ? lanemap_q[15:8] : lanemap_q[7:0];
    wire [3:0] lock_log;
    wire [15:0] edges_w = edges_q + {15'h0, lclk_rise}; // wrap cycle counts too

    // logical lane i reads the physical lane that the map names
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign lock_log[i] = lock_s[map[2*i+1 -: 2]];
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            win_q     <= 10'h0;
            edges_q   <= 16'h0;
            linkcnt_q <= 16'h0;
            link_ok_q <= 1'b0;
            lane_sel  <= 8'(`LANEMAP_RESET);
            cal_q     <= 6'h0;
            term_code <= `TERM_MID;
        end else begin
            win_q <= win_q + 10'h1;
            if (win_q == 10'(`LINK_WIN_CYC - 1)) begin
                edges_q   <= 16'h0;
                linkcnt_q <= edges_w;
                link_ok_q <= edges_w >= `LINK_MIN && edges_w <= `LINK_MAX;
            end else if (lclk_rise && edges_q != 16'hffff) begin
                edges_q <= edges_q + 16'h1;
            end
            lane_sel <= map;
            cal_q <= cal_q + 6'h1;
            if (t_man) begin
                term_code <= t_val;
            end else if (cal_q == 6'(`TERM_CAL_CYC - 1)) begin
                // step toward one fifth of the reference resistor
                if (cal_hi_s && term_code != 4'h0) term_code <= term_code - 4'h1;
                else if (!cal_hi_s && term_code != 4'hf)
                    term_code <= term_code + 4'h1;
            end
        end
    end

    assign rx_step = step_q;

    wire mute  = hdmi & (~link_ok_q | ~ready);
    wire vmute = mute | fmt_err;

    assign status_w = {16'h0, step_q, term_code, lock_log, ready,
                       fmt_err, mute, present_q, hpd_out};

////////////////////////////////////////////////////////////////////////
// packets, audio, stereo

    wire aud_ok = aud_in.valid & (aud_in.layout8 | aud_in.ch <= 3'h1);
    wire [4:0] s3d = map3d(stereo_q); // {valid, structure}

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pktcnt_q       <= 32'h0;
            aud_out        <= '0;
            vsif_3d_valid  <= 1'b0;
            vsif_3d_struct <= 4'h0;
        end else begin
            if (pkt_in.valid && hdmi) begin
                if (pkt_in.ptype == `PT_GCP) pktcnt_q[7:0] <= pktcnt_q[7:0] + 8'h1;
                if (pkt_in.ptype == `PT_ACR) pktcnt_q[15:8] <= pktcnt_q[15:8] + 8'h1;
                if (pkt_in.ptype == `PT_AVI)
                    pktcnt_q[23:16] <= pktcnt_q[23:16] + 8'h1;
            end
            if (aud_ok && !mute) pktcnt_q[31:24] <= pktcnt_q[31:24] + 8'h1;
            aud_out       <= aud_in;
            aud_out.valid <= aud_ok & ~mute;
            vsif_3d_valid  <= s3d[4];
            vsif_3d_struct <= s3d[3:0];
        end
    end

////////////////////////////////////////////////////////////////////////
// formatter: pixel repeat, tmds, terc4, bch

    dphdmi_pkg::vid_t pix_q;
    dphdmi_pkg::isl_t isl_q;
    logic [1:0]  rcnt_q;
    logic [7:0]  ecc_q;
    logic [4:0]  hbit_q;
    logic [4:0]  disp_q [3];

    wire [1:0] rcnt_d = (rcnt_q == 2'h0) ? rep : rcnt_q - 2'h1;
    wire       vid_de = pix_q.de & ~vmute;
    wire       isl_on = isl_q.valid & ~mute & ~vid_de;
    wire       in_hdr = hbit_q < `BCH_DATA_BITS;
    wire       hdr_tx = in_hdr ? isl_q.hdr : ecc_q[0];
    wire       fb     = isl_q.hdr ^ ecc_q[0];
    wire [7:0] lane_d [3];
    wire [3:0] nib    [3];
    wire [9:0] code_d [3];
    wire [14:0] enc   [3];

    assign lane_d[0] = pix_q.b[15:8];
    assign lane_d[1] = pix_q.g[15:8];
    assign lane_d[2] = pix_q.r[15:8];
    assign nib[0]    = {1'b1, hdr_tx, pix_q.vs, pix_q.hs};
    assign nib[1]    = isl_q.d1;
    assign nib[2]    = isl_q.d2;

    // per-lane symbol choice and disparity
    for (genvar i = 0; i < 3; i++) begin : g_tmds
        assign enc[i]    = tmds_enc(lane_d[i], disp_q[i]);
        assign code_d[i] = vid_de ? enc[i][9:0] :
                           isl_on ? terc4(nib[i]) :
                           ctl_tok(i == 0 ? {pix_q.vs, pix_q.hs} : 2'h0);
        always_ff @(posedge sys_clk) begin
            if (!nrst) disp_q[i] <= 5'h0;
            else if (vid_de) disp_q[i] <= enc[i][14:10];
            else disp_q[i] <= 5'h0;
        end
    end

    // pixel held for the repeat count, then the next is taken
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pix_q     <= '0;
            isl_q     <= '0;
            rcnt_q    <= 2'h0;
            vid_ready <= 1'b0;
            ecc_q     <= 8'h0;
            hbit_q    <= 5'h0;
            tmds      <= '0;
        end else begin
            if (rcnt_q == 2'h0) pix_q <= vid_in;
            rcnt_q    <= rcnt_d;
            vid_ready <= rcnt_d == 2'h0;
            isl_q     <= isl_in;
            if (isl_on) begin
                hbit_q <= hbit_q + 5'h1;
                if (!in_hdr) ecc_q <= {1'b0, ecc_q[7:1]};
                else ecc_q <= {1'b0, ecc_q[7:1]} ^ (fb ? `BCH_POLY : 8'h00);
                if (hbit_q == 5'h1f) ecc_q <= 8'h0;
            end
            tmds <= {code_d[2], code_d[1], code_d[0]};
        end
    end

endmodule

// File: dv/conv_chk_assertions.sv
// Purpose: port-level checks of the stream converter
// Assumes: one sys_clk domain, sync active-low reset
// Notes:   bound to the top module below
`timescale 1ns/1ps
module conv_chk #(
    parameter logic [17:0] HPD_PULSE_CYC = 18'd20
) (
    input logic              sys_clk,
    input logic              nrst,
    input logic [3:0]        avs_address,
    input logic              avs_read,
    input logic              avs_write,
    input logic [31:0]       avs_writedata,
    input logic              avs_waitrequest,
    input logic              hpd_in,
    input logic              hpd_out,
    input logic              aux_req,
    input logic              aux_tick,
    input dphdmi_pkg::vid_t  vid_in,
    input dphdmi_pkg::isl_t  isl_in,
    input dphdmi_pkg::aud_t  aud_in,
    input dphdmi_pkg::aud_t  aud_out,
    input dphdmi_pkg::tmds_t tmds,
    input logic              vsif_3d_valid,
    input logic [3:0]        vsif_3d_struct
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    // helper decode: bus writes, stereo map, control token
    logic [7:0]  code_q;
    logic [2:0]  blk1_q;
    logic [2:0]  blk2_q;
    logic [17:0] low_q;
    logic        pend_q;
    wire         wr_done = avs_write && !avs_waitrequest;
    wire         irq_hit = wr_done && avs_address == 4'h0 && avs_writedata[3:0] == 4'h9;
    wire [4:0]   smap = (code_q inside {8'h01, 8'h11, 8'h21, 8'h02}) ? 5'h10 :
                        (code_q inside {8'h03, 8'h13}) ? 5'h12 :
                        (code_q inside {8'h04, 8'h14}) ? 5'h13 : 5'h00;
    wire [9:0]   tok = blk1_q[0] ? (blk1_q[1] ? 10'h2ab : 10'h0ab) :
                                   (blk1_q[1] ? 10'h154 : 10'h354);
    // history of inputs and length of hpd low runs
    always_ff @(posedge sys_clk) begin
        blk1_q <= {!vid_in.de && !isl_in.valid, vid_in.vs, vid_in.hs};
        blk2_q <= blk1_q;
        low_q <= hpd_out ? 18'h0 : low_q + 18'h1;
        pend_q <= nrst && ((irq_hit && hpd_out) || (pend_q && !(hpd_out && low_q != 18'h0)));
        if (wr_done && avs_address == 4'h2) begin
            code_q <= avs_writedata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence fall_s;
        ##[1:3] !hpd_out;
    endsequence
    sequence tick_gap_s;
        !aux_tick [*8] ##92 aux_tick;
    endsequence
    AST_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing wrong");
    AST_TICK: assert property (aux_tick |=> tick_gap_s) else $error("aux tick not 1 us");
    AST_AUD: assert property (aud_out.valid |-> aud_out.data == $past(aud_in.data) &&
        $past(aud_in.valid && (aud_in.layout8 || aud_in.ch <= 3'h1))) else $error("audio out bad");
    AST_STEREO: assert property (wr_done && avs_address == 4'h2 |->
        ##[2:3] {vsif_3d_valid, vsif_3d_struct} == smap) else $error("stereo map wrong");
    AST_IRQ_START: assert property (irq_hit && hpd_out |-> fall_s) else $error("no hpd pulse");
    AST_IRQ_LEN: assert property (pend_q && hpd_out && low_q != 18'h0 |->
        low_q == HPD_PULSE_CYC) else $error("hpd pulse length wrong");
    AST_OFF: assert property (wr_done && avs_address == 4'h0 && !avs_writedata[0] |->
        ##[1:3] !hpd_out [*4]) else $error("hpd high while inactive");
    AST_REQ: assert property (aux_req |-> hpd_in && !$past(hpd_in, 8) ##1 !aux_req)
        else $error("aux request without sink pulse");
    AST_TMDS: assert property (blk1_q == blk2_q && blk1_q[2] && $past(nrst, 3) |->
        tmds.ch0 == tok) else $error("control token wrong");
endmodule
bind dp_hdmi_stream_converter conv_chk #(.HPD_PULSE_CYC(HPD_PULSE_CYC)) u_conv_chk (
    .sys_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
    .hpd_in, .hpd_out, .aux_req, .aux_tick, .vid_in, .isl_in, .aud_in, .aud_out, .tmds,
    .vsif_3d_valid, .vsif_3d_struct);

// File: dv/src_model.sv
// Purpose: upstream source: link clock and training answers
// Assumes: link clock free running at 80 ns
// Notes:   step oks come one per cycle after go
`timescale 1ns/1ps
module src_model (
    input  logic       sys_clk,
    input  logic       train_go,
    output logic       link_clk,
    output logic [7:0] rx_step_ok,
    output logic [3:0] rx_lane_lock
);
    // link clock, phase unrelated to sys_clk
    initial begin
        link_clk = 1'b0;
        #3;
        forever #40 link_clk = ~link_clk;
    end
    // training answers build up slowly
    always @(posedge sys_clk) begin
        rx_lane_lock <= {4{train_go}};
        rx_step_ok <= train_go ? {rx_step_ok[6:0], 1'b1} : 8'h00;
    end
endmodule

// File: dv/tb.sv
// Purpose: self-checking bench of the stream converter
// Assumes: short hpd counts 20/40/80
// Notes:   reads checked from a queue of notes
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("Error %0t: got %h exp %h", $time, a, b); end end
module tb;
    logic sys_clk = 1'b0, nrst = 1'b0, go = 1'b0, hpd_in = 1'b1, term_cal_hi = 1'b0;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, hpd_out, aux_req, link_clk;
    logic [3:0]  avs_address = 4'h0, rx_lane_lock;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, e;
    logic [7:0]  rx_step_ok, lane_sel;
    logic [15:0] rnd = 16'h0030, w;
    dphdmi_pkg::vid_t vid_in = '0;
    dphdmi_pkg::isl_t isl_in = '0;
    dphdmi_pkg::aud_t aud_in = '0;
    dphdmi_pkg::pkt_t pkt_in = '0;
    int failures = 0, checks = 0, cyc = 0, n;
    logic [31:0] expq[$];
    logic [7:0]  sc[12] = '{8'h01, 8'h11, 8'h21, 8'h02, 8'h03, 8'h13, 8'h23, 8'h33, 8'h43,
                            8'h04, 8'h14, 8'h00};
    logic [4:0]  se[12] = '{5'h10, 5'h10, 5'h10, 5'h10, 5'h12, 5'h12, 5'h00, 5'h00, 5'h00,
                            5'h13, 5'h13, 5'h00};
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    dp_hdmi_stream_converter #(.HPD_PULSE_CYC(18'd20), .HPD_IRQ_MAX_CYC(18'd40),
        .HPD_LOSS_CYC(18'd80)) u_dp_hdmi_stream_converter (.sys_clk, .nrst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
        .avs_waitrequest, .link_clk, .hpd_in, .rx_step_ok, .rx_lane_lock, .term_cal_hi, .vid_in,
        .isl_in, .aud_in, .pkt_in, .hpd_out, .aux_req, .aux_kind(), .aux_tick(), .rx_step(),
        .lane_sel, .term_code(), .vid_ready(), .tmds(), .aud_out(), .vsif_3d_valid(),
        .vsif_3d_struct());
    src_model u_src_model (.sys_clk, .train_go(go), .link_clk, .rx_step_ok, .rx_lane_lock);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // one bus access, read notes its expected word
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, x);
        @(posedge sys_clk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= d;
        if (!wr) expq.push_back(x);
        do @(posedge sys_clk); while (avs_waitrequest);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wait_hpd(input logic v);
        repeat (300) if (hpd_out !== v) @(posedge sys_clk);
        `CHK(hpd_out, v)
    endtask
    // random traffic, timeout, read monitor
    always @(posedge sys_clk) begin
        cyc++;
        rnd <= lfsr(rnd);
        vid_in <= dphdmi_pkg::vid_t'(51'({4{rnd}}));
        isl_in <= dphdmi_pkg::isl_t'(rnd[9:0]);
        aud_in <= dphdmi_pkg::aud_t'(37'({3{rnd}}));
        pkt_in <= dphdmi_pkg::pkt_t'(rnd[8:0]);
        term_cal_hi <= rnd[3];
        if (avs_read && !avs_waitrequest) begin
            e = expq.pop_front();
            `CHK(avs_readdata, e)
        end
        if (cyc == 20000) begin
            failures++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        wait_hpd(1'b0);
        bus(1'b0, 4'h1, 32'h0, 32'h0000e4e4);
        bus(1'b1, 4'hf, 32'hffffffff, 32'h0);
        bus(1'b0, 4'hf, 32'h0, 32'h0);
        w = rnd;
        bus(1'b1, 4'h1, {16'h0, w}, 32'h0);
        bus(1'b0, 4'h1, 32'h0, {16'h0, w});
        `CHK(lane_sel, w[7:0])
        foreach (sc[i]) begin
            bus(1'b1, 4'h2, {24'h0, sc[i]}, 32'h0);
            bus(1'b0, 4'h2, 32'h0, {15'h0, se[i][4], 4'h0, se[i][3:0], sc[i]});
        end
        go <= 1'b1;
        bus(1'b1, 4'h0, 32'h1, 32'h0);
        wait_hpd(1'b1);
        bus(1'b1, 4'h0, 32'h9, 32'h0);
        wait_hpd(1'b0);
        n = 0;
        while (!hpd_out && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK(n, 20)
        bus(1'b1, 4'h4, 32'h3, 32'h0);
        hpd_in <= 1'b0;
        repeat (15) @(posedge sys_clk);
        hpd_in <= 1'b1;
        n = 0;
        while (aux_req !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK(aux_req, 1'b1)
        bus(1'b0, 4'h4, 32'h0, 32'h1);
        hpd_in <= 1'b0;
        repeat (100) @(posedge sys_clk);
        bus(1'b0, 4'h4, 32'h0, 32'h3);
        hpd_in <= 1'b1;
        repeat (1100) @(posedge sys_clk);
        bus(1'b0, 4'h5, 32'h0, 32'h80);
        bus(1'b1, 4'h0, 32'h0, 32'h0);
        wait_hpd(1'b0);
        repeat (4) @(posedge sys_clk);
        finish_test();
    end
endmodule
